// ### design/bsw_button_qual.sv
// Push-button synchroniser and low-time qualifier.
// Assumes an active-low, asynchronous, bouncing button input.
`timescale 1ns/10ps
module bsw_button_qual
   import bsw_pkg::*;
#(
   parameter int unsigned SHORT_CYC = DEGLITCH_CYC,
   parameter int unsigned LONG_CYC = HOLD_CYC
) (
   // Clock, reset, enable
   input wire logic clk_i,
   input wire logic rst_n_i,
   input wire logic ce_i,
   // Button
   input wire logic push_button_n_i,
   // Qualified events
   output logic short_o,
   output logic long_o,
   output logic low_o
);

   logic sync1_r;            // First synchroniser stage
   logic sync2_r;            // Second synchroniser stage
   logic [CNT_W-1:0] cnt_r;  // Low time so far
   logic short_r;            // Deglitch time reached
   logic long_r;             // Hold time reached

   //--------------------------------------------------------------------
   // Synchroniser
   //--------------------------------------------------------------------
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         sync1_r <= 1'b1;
         sync2_r <= 1'b1;
      end else if (ce_i) begin
         sync1_r <= push_button_n_i;
         sync2_r <= sync1_r;
      end
   end

   //--------------------------------------------------------------------
   // Low time measurement
   //--------------------------------------------------------------------
   // Counter saturates at the long figure; high restarts it
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         cnt_r <= '0;
         short_r <= 1'b0;
         long_r <= 1'b0;
      end else if (ce_i) begin
         short_r <= !sync2_r && (cnt_r == CNT_W'(SHORT_CYC - 1));
         long_r <= !sync2_r && (cnt_r == CNT_W'(LONG_CYC - 1));
         if (sync2_r) begin
            cnt_r <= '0;
         end else if (cnt_r != CNT_W'(LONG_CYC)) begin
            cnt_r <= cnt_r + 1'b1;
         end
      end
   end

   assign short_o = short_r;
   assign long_o = long_r;
   assign low_o = (cnt_r >= CNT_W'(SHORT_CYC));

endmodule : bsw_button_qual

// ### design/bsw_ctrl.sv
// Battery switch, ship mode and system power-cycle controller.
// Assumes a single 25 MHz clock, synchronous register port strobes and
// a level input that says the input supply is valid.
`timescale 1ns/10ps
module bsw_ctrl
   import bsw_pkg::*;
#(
   parameter int unsigned ENTRY_CYC = ENTRY_DELAY_CYC,
   parameter int unsigned SHORT_CYC = DEGLITCH_CYC,
   parameter int unsigned LONG_CYC = HOLD_CYC,
   parameter int unsigned OFF_TIME_CYC = OFF_CYC
) (
   // Clock, reset, enable
   input wire logic clk_i,
   input wire logic rst_n_i,
   input wire logic ce_i,
   // Register port
   input wire logic [ADDR_W-1:0] addr_i,
   input wire logic [DATA_W-1:0] wr_data_i,
   input wire logic wr_i,
   input wire logic rd_i,
   output logic [DATA_W-1:0] rd_data_o,
   // Board inputs
   input wire logic vbus_valid_i,
   input wire logic push_button_n_i,
   // Power control outputs
   output logic battery_switch_o,
   output logic ship_mode_o,
   output logic input_highz_enable_o,
   output logic boost_output_enable_o
);

   //--------------------------------------------------------------------
   // Declarations
   //--------------------------------------------------------------------
   bsw_state_e state_r;             // Controller state
   bsw_state_e state_nxt;           // Next controller state
   logic sor_r;                     // Switch-off request
   logic dly_r;                     // Entry delay select
   logic bre_r;                     // Button reset enable
   logic hiz_r;                     // Input high-z enable
   logic boost_r;                   // Boost output enable
   logic sw_r;                      // Battery switch closed
   logic ship_r;                    // Ship mode flag
   logic vbus_prev_r;               // Supply level one cycle ago
   logic [DATA_W-1:0] rd_data_r;    // Read data
   logic wr_ctrl;                   // Write to control register
   logic reg_rst;                   // Register reset request
   logic vbus_rise;                 // Supply just connected
   logic btn_short;                 // Deglitched press
   logic btn_long;                  // Long press
   logic btn_low;                   // Button held past deglitch
   logic tmr_load;                  // Start timer
   logic tmr_cancel;                // Stop timer
   logic [CNT_W-1:0] tmr_val;       // Timer load value
   logic tmr_done;                  // Timer expired
   logic tmr_busy;                  // Timer running
   logic exit_clr;                  // Ship exit clears the request
   logic btn_exit;                  // Ship exit by the button

   //--------------------------------------------------------------------
   // Helpers
   //--------------------------------------------------------------------
   // Address match for one register
   function automatic logic addr_hit(input logic [ADDR_W-1:0] a,
                                     input logic [ADDR_W-1:0] reg_a);
      addr_hit = (a == reg_a);
   endfunction : addr_hit

   // Switch closed in a given state
   function automatic logic sw_closed(input bsw_state_e s);
      sw_closed = (s == BSW_ON) || (s == BSW_ENTRY_WAIT);
   endfunction : sw_closed

   //--------------------------------------------------------------------
   // Sub-blocks
   //--------------------------------------------------------------------
   // Button qualifier
   bsw_button_qual #(
      .SHORT_CYC(SHORT_CYC),
      .LONG_CYC(LONG_CYC)
   ) u_button (
      .clk_i(clk_i),
      .rst_n_i(rst_n_i),
      .ce_i(ce_i),
      .push_button_n_i(push_button_n_i),
      .short_o(btn_short),
      .long_o(btn_long),
      .low_o(btn_low)
   );

   // Shared delay timer
   bsw_timer u_timer (
      .clk_i(clk_i),
      .rst_n_i(rst_n_i),
      .ce_i(ce_i),
      .load_i(tmr_load),
      .cancel_i(tmr_cancel),
      .load_val_i(tmr_val),
      .done_o(tmr_done),
      .busy_o(tmr_busy)
   );

   //--------------------------------------------------------------------
   // Register port decode
   //--------------------------------------------------------------------
   assign wr_ctrl = wr_i && addr_hit(addr_i, CTRL_ADDR);
   assign reg_rst = wr_ctrl && wr_data_i[CTRL_RRST_BIT];
   assign vbus_rise = vbus_valid_i && !vbus_prev_r;

   //--------------------------------------------------------------------
   // Next state and timer control
   //--------------------------------------------------------------------
   always_comb begin
      state_nxt = state_r;
      tmr_load = 1'b0;
      tmr_cancel = 1'b0;
      tmr_val = '0;
      exit_clr = 1'b0;
      btn_exit = 1'b0;
      if (reg_rst) begin
         // Register reset ends any sequence at once
         state_nxt = BSW_ON;
         tmr_cancel = 1'b1;
      end else begin
         unique case (state_r)
            BSW_ON: begin
               if (sor_r && !dly_r) begin
                  state_nxt = BSW_SHIP;
               end else if (sor_r) begin
                  // Delayed entry
                  state_nxt = BSW_ENTRY_WAIT;
                  tmr_load = 1'b1;
                  tmr_val = CNT_W'(ENTRY_CYC);
               end else if (btn_long && !vbus_valid_i && bre_r) begin
                  // Long press without supply
                  state_nxt = BSW_CYCLE_OFF;
                  tmr_load = 1'b1;
                  tmr_val = CNT_W'(OFF_TIME_CYC);
               end
            end
            BSW_ENTRY_WAIT: begin
               if (!sor_r) begin
                  // Request withdrawn before expiry
                  state_nxt = BSW_ON;
                  tmr_cancel = 1'b1;
               end else if (!dly_r) begin
                  // Delay dropped while waiting: open now
                  state_nxt = BSW_SHIP;
                  tmr_cancel = 1'b1;
               end else if (tmr_done) begin
                  state_nxt = BSW_SHIP;
               end
            end
            BSW_SHIP: begin
               if (btn_short) begin
                  // Deglitched press, with or without supply
                  state_nxt = BSW_ON;
                  exit_clr = 1'b1;
                  btn_exit = 1'b1;
               end else if (vbus_rise) begin
                  state_nxt = BSW_ON;
                  exit_clr = 1'b1;
               end else if (!sor_r) begin
                  // Host cleared the request
                  state_nxt = BSW_ON;
               end
            end
            BSW_CYCLE_OFF: begin
               if (tmr_done) begin
                  state_nxt = BSW_ON;
               end
            end
         endcase
      end
   end

   //--------------------------------------------------------------------
   // State and switch outputs
   //--------------------------------------------------------------------
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         state_r <= BSW_ON;
         sw_r <= 1'b1;
         ship_r <= 1'b0;
      end else if (ce_i) begin
         state_r <= state_nxt;
         sw_r <= sw_closed(state_nxt);
         ship_r <= (state_nxt == BSW_SHIP);
      end
   end

   //--------------------------------------------------------------------
   // Supply edge detector
   //--------------------------------------------------------------------
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         vbus_prev_r <= 1'b0;
      end else if (ce_i) begin
         vbus_prev_r <= vbus_valid_i;
      end
   end

   //--------------------------------------------------------------------
   // Switch-off request
   //--------------------------------------------------------------------
   // A host write in the same cycle as an exit wins over the clear
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         sor_r <= CTRL_RESET[CTRL_SOR_BIT];
      end else if (ce_i) begin
         if (reg_rst) begin
            sor_r <= CTRL_RESET[CTRL_SOR_BIT];
         end else if (wr_ctrl) begin
            sor_r <= wr_data_i[CTRL_SOR_BIT];
         end else if (exit_clr) begin
            sor_r <= 1'b0;
         end
      end
   end

   //--------------------------------------------------------------------
   // Delay select and button reset enable
   //--------------------------------------------------------------------
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         dly_r <= CTRL_RESET[CTRL_DLY_BIT];
         bre_r <= CTRL_RESET[CTRL_BRE_BIT];
      end else if (ce_i) begin
         if (reg_rst) begin
            dly_r <= CTRL_RESET[CTRL_DLY_BIT];
            bre_r <= CTRL_RESET[CTRL_BRE_BIT];
         end else if (wr_ctrl) begin
            dly_r <= wr_data_i[CTRL_DLY_BIT];
            bre_r <= wr_data_i[CTRL_BRE_BIT];
         end
      end
   end

   //--------------------------------------------------------------------
   // Input high-z enable
   //--------------------------------------------------------------------
   // Button exit sets it; the set wins over a host write
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         hiz_r <= CTRL_RESET[CTRL_HIZ_BIT];
      end else if (ce_i) begin
         if (reg_rst) begin
            hiz_r <= CTRL_RESET[CTRL_HIZ_BIT];
         end else if (btn_exit) begin
            hiz_r <= 1'b1;
         end else if (wr_ctrl) begin
            hiz_r <= wr_data_i[CTRL_HIZ_BIT];
         end
      end
   end

   //--------------------------------------------------------------------
   // Boost output enable
   //--------------------------------------------------------------------
   // Setting is only taken once high-z is already clear
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         boost_r <= CTRL_RESET[CTRL_BOOST_BIT];
      end else if (ce_i) begin
         if (reg_rst) begin
            boost_r <= CTRL_RESET[CTRL_BOOST_BIT];
         end else if (btn_exit) begin
            boost_r <= 1'b0;
         end else if (wr_ctrl) begin
            boost_r <= wr_data_i[CTRL_BOOST_BIT] && !hiz_r
                       && !wr_data_i[CTRL_HIZ_BIT];
         end
      end
   end

   //--------------------------------------------------------------------
   // Read data
   //--------------------------------------------------------------------
   // Data stands one cycle after the strobe, zero otherwise
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         rd_data_r <= '0;
      end else if (ce_i) begin
         rd_data_r <= '0;
         if (rd_i && addr_hit(addr_i, CTRL_ADDR)) begin
            rd_data_r[CTRL_SOR_BIT] <= sor_r;
            rd_data_r[CTRL_DLY_BIT] <= dly_r;
            rd_data_r[CTRL_BRE_BIT] <= bre_r;
            rd_data_r[CTRL_HIZ_BIT] <= hiz_r;
            rd_data_r[CTRL_BOOST_BIT] <= boost_r;
         end else if (rd_i && addr_hit(addr_i, STAT_ADDR)) begin
            rd_data_r[STAT_SW_BIT] <= sw_r;
            rd_data_r[STAT_SHIP_BIT] <= ship_r;
            rd_data_r[STAT_CYC_BIT] <= (state_r == BSW_CYCLE_OFF);
            rd_data_r[STAT_VBUS_BIT] <= vbus_valid_i;
            rd_data_r[STAT_BTN_BIT] <= btn_low;
            rd_data_r[STAT_WAIT_BIT] <= tmr_busy
                                        && (state_r == BSW_ENTRY_WAIT);
         end
      end
   end

   //--------------------------------------------------------------------
   // Outputs
   //--------------------------------------------------------------------
   assign rd_data_o = rd_data_r;
   assign battery_switch_o = sw_r;
   assign ship_mode_o = ship_r;
   assign input_highz_enable_o = hiz_r;
   assign boost_output_enable_o = boost_r;

endmodule : bsw_ctrl

// ### design/bsw_pkg.sv
//----------------------------------------------------------------------
// Constants for the battery switch and ship mode controller
//----------------------------------------------------------------------
// Holds register offsets, field positions, reset values, timing figures
// and the controller state type. Assumes a 25 MHz core clock.
//
// What this block does
// - Switch-off request, no delay: open switch immediately
// - Switch-off request with delay: wait entry delay
// - Input supply arriving closes switch, ends ship mode
// - Button held low deglitch time closes switch
// - Host clearing switch-off request re-enables switch
// - Register reset bit restores defaults, ends ship
// - Qualified button pulse also ends ship mode
// - Long button hold, no supply: start power cycle
// - Power cycle keeps switch open, then recloses
// - Button reset enable clear blocks power cycle
// - Button exit from ship mode sets high-impedance bit
// - Boost enable refused while high-impedance bit set
package bsw_pkg;

   //--------------------------------------------------------------------
   // Register bus
   //--------------------------------------------------------------------
   localparam int unsigned ADDR_W = 8;  // Address width
   localparam int unsigned DATA_W = 8;  // Data width
   localparam logic [ADDR_W-1:0] CTRL_ADDR = 8'h00;  // Control register
   localparam logic [ADDR_W-1:0] STAT_ADDR = 8'h04;  // Status register

   //--------------------------------------------------------------------
   // Control register fields
   //--------------------------------------------------------------------
   localparam int unsigned CTRL_SOR_BIT = 0;    // Switch-off request
   localparam int unsigned CTRL_DLY_BIT = 1;    // Entry delay select
   localparam int unsigned CTRL_BRE_BIT = 2;    // Button reset enable
   localparam int unsigned CTRL_HIZ_BIT = 3;    // Input high-z enable
   localparam int unsigned CTRL_BOOST_BIT = 4;  // Boost output enable
   localparam int unsigned CTRL_RRST_BIT = 7;   // Register reset, self clear
   localparam logic [DATA_W-1:0] CTRL_RESET = 8'h04;  // Default value

   //--------------------------------------------------------------------
   // Status register fields
   //--------------------------------------------------------------------
   localparam int unsigned STAT_SW_BIT = 0;     // Battery switch closed
   localparam int unsigned STAT_SHIP_BIT = 1;   // Ship mode active
   localparam int unsigned STAT_CYC_BIT = 2;    // Power cycle active
   localparam int unsigned STAT_VBUS_BIT = 3;   // Input supply valid
   localparam int unsigned STAT_BTN_BIT = 4;    // Button low, debounced
   localparam int unsigned STAT_WAIT_BIT = 5;   // Entry delay running

   //--------------------------------------------------------------------
   // Timing
   //--------------------------------------------------------------------
   localparam int unsigned CNT_W = 32;              // Counter width
   localparam int unsigned CLK_KHZ = 25000;         // Core clock in kHz
   localparam int unsigned ENTRY_DELAY_MS = 12300;  // Ship entry delay
   localparam int unsigned DEGLITCH_MS = 1000;      // Exit deglitch time
   localparam int unsigned HOLD_MS = 10000;         // Reset hold time
   localparam int unsigned OFF_MS = 320;            // Reset off time
   localparam int unsigned ENTRY_DELAY_CYC = CLK_KHZ * ENTRY_DELAY_MS;
   localparam int unsigned DEGLITCH_CYC = CLK_KHZ * DEGLITCH_MS;
   localparam int unsigned HOLD_CYC = CLK_KHZ * HOLD_MS;
   localparam int unsigned OFF_CYC = CLK_KHZ * OFF_MS;

   //--------------------------------------------------------------------
   // Controller states
   //--------------------------------------------------------------------
   typedef enum logic [1:0] {
      BSW_ON,
      BSW_ENTRY_WAIT,
      BSW_SHIP,
      BSW_CYCLE_OFF
   } bsw_state_e;

endpackage : bsw_pkg

// ### design/bsw_timer.sv
// One-shot down counter used for the entry delay and the power cycle.
// Assumes one load or cancel at a time from the controller.
`timescale 1ns/10ps
module bsw_timer
   import bsw_pkg::*;
(
   // Clock, reset, enable
   input wire logic clk_i,
   input wire logic rst_n_i,
   input wire logic ce_i,
   // Control
   input wire logic load_i,
   input wire logic cancel_i,
   input wire logic [CNT_W-1:0] load_val_i,
   // Status
   output logic done_o,
   output logic busy_o
);

   logic [CNT_W-1:0] cnt_r;  // Cycles left
   logic done_r;             // Expiry pulse

   //--------------------------------------------------------------------
   // Counter
   //--------------------------------------------------------------------
   // Cancel beats load so a reset never leaves a stale count
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         cnt_r <= '0;
         done_r <= 1'b0;
      end else if (ce_i) begin
         done_r <= 1'b0;
         if (cancel_i) begin
            cnt_r <= '0;
         end else if (load_i) begin
            cnt_r <= load_val_i;
         end else if (cnt_r != '0) begin
            cnt_r <= cnt_r - 1'b1;
            done_r <= (cnt_r == CNT_W'(1));
         end
      end
   end

   assign done_o = done_r;
   assign busy_o = (cnt_r != '0);

endmodule : bsw_timer

// ### verification/bsw_button_model.sv
// Push-button model: holds the line low for a commanded count.
// Assumes a pull-up, so a released button reads high.
`timescale 1ns/10ps
module bsw_button_model (
   // Clock and command
   input wire logic clk_i,
   input wire logic start_i,
   input wire logic [15:0] len_i,
   // Button line
   output logic push_button_n_o
);
   logic [15:0] cnt_r = 16'h0000;  // Cycles left pressed
   // Load on start, count down while held
   always @(posedge clk_i) begin
      if (start_i) begin
         cnt_r <= len_i;
      end else if (cnt_r != 16'h0000) begin
         cnt_r <= cnt_r - 16'h0001;
      end
   end
   // High to low press held for the count
   assign push_button_n_o = (cnt_r == 16'h0000);
endmodule : bsw_button_model

// ### verification/bsw_ctrl_bench.sv
// Bench for the battery switch controller, short timing parameters.
// Assumes the button model and the bound checker.
`timescale 1ns/10ps
module bsw_ctrl_bench
   import bsw_pkg::*;
;
   localparam int unsigned EC = 40;
   localparam int unsigned SC = 10;
   localparam int unsigned LC = 30;
   localparam int unsigned OC = 20;
   logic clk_i = 1'b0;
   logic rst_n_i = 1'b0;
   logic [ADDR_W-1:0] addr_i = 8'h00;
   logic [DATA_W-1:0] wr_data_i = 8'h00;
   logic wr_i = 1'b0;
   logic rd_i = 1'b0;
   logic ce_i = 1'b1;
   logic vbus_valid_i = 1'b0;
   logic go = 1'b0;
   logic [15:0] plen = 16'h0000;
   logic [DATA_W-1:0] rd_data_o;
   logic [DATA_W-1:0] d;
   logic btn_n, sw_o, ship_o, hiz_o, boost_o;
   int err_total = 0;
   int checks_done = 0;
   int cyc = 0;
   always #20 clk_i = ~clk_i;
   bsw_ctrl #(.ENTRY_CYC(EC), .SHORT_CYC(SC), .LONG_CYC(LC),
      .OFF_TIME_CYC(OC)) dut (.clk_i(clk_i), .rst_n_i(rst_n_i), .ce_i(ce_i),
      .addr_i(addr_i), .wr_data_i(wr_data_i), .wr_i(wr_i), .rd_i(rd_i),
      .rd_data_o(rd_data_o), .vbus_valid_i(vbus_valid_i),
      .push_button_n_i(btn_n), .battery_switch_o(sw_o), .ship_mode_o(ship_o),
      .input_highz_enable_o(hiz_o), .boost_output_enable_o(boost_o));
   bsw_button_model u_btn (.clk_i(clk_i), .start_i(go), .len_i(plen),
      .push_button_n_o(btn_n));
   task automatic tally_and_finish;
      $display("checks %0d mismatches %0d", checks_done, err_total);
      if (err_total == 0 && checks_done > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask : tally_and_finish
   task automatic chk(input string nm, input logic [7:0] e,
                      input logic [7:0] g);
      checks_done++;
      if (g !== e) begin
         err_total++;
         $display("[ERR] %s expected %h seen %h", nm, e, g);
      end
   endtask : chk
   // Outputs as {switch, ship, hiz, boost}
   task automatic see(input string nm, input logic [3:0] e);
      chk(nm, {4'h0, e}, {4'h0, sw_o, ship_o, hiz_o, boost_o});
   endtask : see
   task automatic wreg(input logic [7:0] a, input logic [7:0] v);
      @(posedge clk_i);
      addr_i <= a;
      wr_data_i <= v;
      wr_i <= 1'b1;
      @(posedge clk_i);
      wr_i <= 1'b0;
   endtask : wreg
   task automatic rreg(input logic [7:0] a);
      @(posedge clk_i);
      addr_i <= a;
      rd_i <= 1'b1;
      @(posedge clk_i);
      rd_i <= 1'b0;
      #1 d = rd_data_o;
   endtask : rreg
   task automatic wt(input int n);
      repeat (n) @(posedge clk_i);
      #1;
   endtask : wt
   task automatic press(input int n);
      @(posedge clk_i);
      plen <= 16'(n);
      go <= 1'b1;
      @(posedge clk_i);
      go <= 1'b0;
   endtask : press
   // Hang guard
   always @(posedge clk_i) begin
      cyc++;
      if (cyc == 3000) begin
         err_total++;
         tally_and_finish();
      end
   end
   initial begin
      repeat (20) @(posedge clk_i);
      rst_n_i <= 1'b1;
      rreg(CTRL_ADDR); chk("ctrl", CTRL_RESET, d);
      rreg(STAT_ADDR); chk("status", 8'h01, d);
      rreg(8'h10); chk("unmapped", 8'h00, d);
      $display("test reset done");
      // Clock enable low: a write must not be taken
      ce_i <= 1'b0;
      wreg(CTRL_ADDR, 8'h05); wt(3); see("frozen", 4'b1000);
      ce_i <= 1'b1;
      for (int v = 0; v < 2; v++) begin
         vbus_valid_i <= v[0];
         wreg(CTRL_ADDR, 8'h05); wt(3); see("ship", 4'b0100);
         press(3); wt(8); see("glitch", 4'b0100);
         rreg(STAT_ADDR); chk("ship st", {4'h0, v[0], 3'b010}, d);
         press(SC + 6); wt(SC + 10); see("btn", 4'b1010);
      end
      wreg(CTRL_ADDR, 8'h1C); wt(2); see("boost hiz", 4'b1010);
      wreg(CTRL_ADDR, 8'h14); wt(2); see("boost refused", 4'b1000);
      wreg(CTRL_ADDR, 8'h14); wt(2); see("boost", 4'b1001);
      $display("test button exit done");
      vbus_valid_i <= 1'b0;
      wreg(CTRL_ADDR, 8'h07); wt(10); see("wait", 4'b1000);
      rreg(STAT_ADDR); chk("wait st", 8'h21, d);
      wt(EC); see("late", 4'b0100);
      vbus_valid_i <= 1'b1;
      wt(5); see("supply", 4'b1000);
      $display("test delay done");
      for (int v = 1; v >= 0; v--) begin
         vbus_valid_i <= v[0];
         wreg(CTRL_ADDR, 8'h05); wt(3); see("off", 4'b0100);
         wreg(CTRL_ADDR, 8'h04); wt(3); see("on", 4'b1000);
      end
      wreg(CTRL_ADDR, 8'h05);
      wreg(CTRL_ADDR, 8'h80); wt(2); see("rrst", 4'b1000);
      rreg(CTRL_ADDR); chk("ctrl", CTRL_RESET, d);
      $display("test host exit done");
      press(LC - 10); wt(LC - 5);
      press(LC - 5); wt(LC); see("restart", 4'b1000);
      press(LC + 10); wt(LC + 10); see("cyc off", 4'b0000);
      rreg(STAT_ADDR); chk("cyc st", 8'h14, d);
      wt(OC + 10); see("cyc on", 4'b1000);
      wreg(CTRL_ADDR, 8'h00);
      press(LC + 10); wt(LC + 12); see("no cyc", 4'b1000);
      $display("test power cycle done");
      tally_and_finish();
   end
endmodule : bsw_ctrl_bench

// ### verification/bsw_ctrl_chk.sv
// Port checker for the battery switch controller.
// Assumes the short timing parameters that the bench sets.
`timescale 1ns/10ps
module bsw_ctrl_chk
   import bsw_pkg::*;
#(
   parameter int unsigned ENTRY_CYC = ENTRY_DELAY_CYC,
   parameter int unsigned OFF_TIME_CYC = OFF_CYC
) (
   // Clock, reset, enable
   input wire logic clk_i,
   input wire logic rst_n_i,
   input wire logic ce_i,
   // Register port
   input wire logic [ADDR_W-1:0] addr_i,
   input wire logic [DATA_W-1:0] wr_data_i,
   input wire logic wr_i,
   input wire logic rd_i,
   input wire logic [DATA_W-1:0] rd_data_o,
   // Board and power outputs
   input wire logic vbus_valid_i,
   input wire logic push_button_n_i,
   input wire logic battery_switch_o,
   input wire logic ship_mode_o,
   input wire logic input_highz_enable_o,
   input wire logic boost_output_enable_o
);
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!rst_n_i);
   // Control register write taken
   logic cw;
   assign cw = wr_i && ce_i && addr_i == CTRL_ADDR && !wr_data_i[7];
   // Switch running normally
   logic on_st;
   assign on_st = battery_switch_o && !ship_mode_o;
   // Power cycle begins: switch drops without ship mode
   sequence s_cyc;
      $fell(battery_switch_o) && !ship_mode_o ##1 !battery_switch_o;
   endsequence
   // Button glitch shorter than the deglitch time while shipped
   sequence s_glitch;
      ship_mode_o && !vbus_valid_i && !wr_i && push_button_n_i
         ##1 !push_button_n_i[*3] ##1 push_button_n_i;
   endsequence
   property p_now_off;
      cw && wr_data_i[1:0] == 2'b01 && on_st |-> ##2 !on_st && ship_mode_o;
   endproperty
   property p_delay;
      cw && wr_data_i[1:0] == 2'b11 && on_st |=> battery_switch_o[*8];
   endproperty
   property p_vbus;
      ship_mode_o && $rose(vbus_valid_i) |-> ##[1:4] on_st;
   endproperty
   property p_clear;
      ship_mode_o && cw && !wr_data_i[0] |-> ##[1:3] on_st;
   endproperty
   property p_regrst;
      wr_i && ce_i && addr_i == CTRL_ADDR && wr_data_i[7] |-> ##[1:2]
         on_st && !input_highz_enable_o && !boost_output_enable_o;
   endproperty
   property p_cycle;
      s_cyc |-> !battery_switch_o[*8] ##[5:14] battery_switch_o;
   endproperty
   property p_boost;
      $rose(boost_output_enable_o) |-> !input_highz_enable_o;
   endproperty
   property p_glitch;
      s_glitch |=> ship_mode_o;
   endproperty
   a_now_off: assert property (p_now_off) else $error("late open");
   a_delay: assert property (p_delay) else $error("opened early");
   a_vbus: assert property (p_vbus) else $error("supply no exit");
   a_clear: assert property (p_clear) else $error("clear no exit");
   a_regrst: assert property (p_regrst) else $error("reg rst bad");
   a_cycle: assert property (p_cycle) else $error("cycle off bad");
   a_boost: assert property (p_boost) else $error("boost with hiz");
   a_glitch: assert property (p_glitch) else $error("glitch exit");
endmodule : bsw_ctrl_chk
bind bsw_ctrl bsw_ctrl_chk #(.ENTRY_CYC(ENTRY_CYC),
   .OFF_TIME_CYC(OFF_TIME_CYC))
   u_chk (.clk_i(clk_i), .rst_n_i(rst_n_i), .ce_i(ce_i), .addr_i(addr_i),
   .wr_data_i(wr_data_i), .wr_i(wr_i), .rd_i(rd_i), .rd_data_o(rd_data_o),
   .vbus_valid_i(vbus_valid_i), .push_button_n_i(push_button_n_i),
   .battery_switch_o(battery_switch_o), .ship_mode_o(ship_mode_o),
   .input_highz_enable_o(input_highz_enable_o),
   .boost_output_enable_o(boost_output_enable_o));
